// file: logic/cefi_fault_irq.sv
// fault flag, receive fault count and interrupt flag logic of a CAN node
// assumes a decoded register command port on sys_clk and a protocol
// engine on linkClk that supplies counts, bit samples and receive events
// How it works
// - receive fault count reads at 0x1D, eight bits, zero after reset
// - send/receive warn bits follow their count at or above 96
// - any-warn bit set if either count reaches 96, else clear
// - passive flags at bits 4 and 3, host cannot write them
// - passive flag high while its count is 128 or more
// - bus-off on send count overflow, cleared after 128 runs of 11 recessive
// - eight interrupt sources, each with enable and flag bit
// - interrupt pin low while any enabled flag stays set
// - host clear of a flag is ignored while its condition persists
// - host may set flags, raising an interrupt like hardware would
module cefi_fault_irq
  import cefi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire cefi_cmd_t cmd,
  output logic rdValid,
  output logic [7:0] rdData,
  input wire logic [IRQ_SOURCES-1:0] irqEvent,
  input wire logic [IRQ_SOURCES-1:0] irqCond,
  output logic irqN,
  input wire logic linkClk,
  input wire logic [7:0] linkSendCount,
  input wire logic [7:0] linkRecvCount,
  input wire logic linkSendOverflow,
  input wire logic linkRecessive,
  input wire logic [1:0] linkRxAccept
);

  function automatic logic [7:0] applyCmd(input logic [7:0] old,
                                         input cefi_cmd_t c);
    logic [7:0] r;
    r = old;
    if (c.op == CEFI_OP_WRITE) begin
      r = c.data;
    end else if (c.op == CEFI_OP_MODIFY) begin
      r = (old & ~c.mask) | (c.data & c.mask);
    end
    return r;
  endfunction

  function automatic logic isWrite(input cefi_cmd_t c,
                                   input logic [7:0] a);
    return c.valid && (c.addr == a) &&
      (c.op == CEFI_OP_WRITE || c.op == CEFI_OP_MODIFY);
  endfunction

  // link-side reset: rst crosses as a level through three flops
  logic [2:0] linkRstPipe;
  logic linkRst;
  always_ff @(posedge linkClk) begin
    linkRstPipe <= {linkRstPipe[1:0], rst};
  end
  assign linkRst = linkRstPipe[2] | linkRstPipe[1];

  // bus-off tracking runs at bit rate on the link clock
  logic linkBusOff;
  logic [3:0] runLen;
  logic [6:0] runCount;
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkBusOff <= 1'b0;
      runLen <= 4'h0;
      runCount <= 7'h00;
    end else if (!linkBusOff) begin
      runLen <= 4'h0;
      runCount <= 7'h00;
      if (linkSendOverflow) begin
        linkBusOff <= 1'b1;
      end
    end else if (!linkRecessive) begin
      runLen <= 4'h0;
    end else if (runLen == 4'(RUN_LEN - 1)) begin
      runLen <= 4'h0;
      if (runCount == 7'(RUN_COUNT - 1)) begin
        linkBusOff <= 1'b0;
        runCount <= 7'h00;
      end else begin
        runCount <= runCount + 7'h01;
      end
    end else begin
      runLen <= runLen + 4'h1;
    end
  end

  // count snapshot handshake: data is held until the ack returns
  cefi_snap_t linkSnap;
  logic linkReq;
  logic [2:0] linkAckSync;
  logic sysAck;
  always_ff @(posedge linkClk) begin
    linkAckSync <= {linkAckSync[1:0], sysAck};
  end
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkReq <= 1'b0;
      linkSnap <= '0;
    end else if (linkAckSync[2] == linkAckSync[1] &&
                 linkAckSync[2] == linkReq) begin
      linkSnap <= '{linkSendCount, linkRecvCount, linkBusOff};
      linkReq <= ~linkReq;
    end
  end

  // receive events cross as toggles, one per buffer
  logic [1:0] linkRxTog;
  logic [1:0] rxEvt;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rx
      logic [2:0] sync;
      logic seen;
      always_ff @(posedge linkClk) begin
        if (linkRst) begin
          linkRxTog[gi] <= 1'b0;
        end else if (linkRxAccept[gi]) begin
          linkRxTog[gi] <= ~linkRxTog[gi];
        end
      end
      always_ff @(posedge sys_clk) begin
        sync <= {sync[1:0], linkRxTog[gi]};
      end
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          seen <= 1'b0;
        end else if (rxEvt[gi]) begin
          seen <= sync[2];
        end
      end
      assign rxEvt[gi] = (sync[2] == sync[1]) && (sync[2] != seen);
    end
  endgenerate

  // sys-side capture of the snapshot
  logic [2:0] reqSync;
  logic snapNew;
  cefi_snap_t snap;
  always_ff @(posedge sys_clk) begin
    reqSync <= {reqSync[1:0], linkReq};
  end
  assign snapNew = (reqSync[2] == reqSync[1]) && (reqSync[2] != sysAck);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sysAck <= 1'b0;
      snap <= '0;
    end else if (snapNew) begin
      sysAck <= reqSync[2];
      snap <= linkSnap;
    end
  end

  // status bits derived every cycle from the latest counts
  logic [5:0] next_status;
  logic [5:0] status;
  always_comb begin
    next_status = '0;
    next_status[FF_BUS_OFF] = snap.busOff;
    next_status[FF_SEND_PASSIVE] = snap.sendCount >= PASSIVE_LIMIT;
    next_status[FF_RECV_PASSIVE] = snap.recvCount >= PASSIVE_LIMIT;
    next_status[FF_SEND_WARN] = snap.sendCount >= WARN_LIMIT;
    next_status[FF_RECV_WARN] = snap.recvCount >= WARN_LIMIT;
    next_status[FF_ANY_WARN] = next_status[FF_SEND_WARN] |
                               next_status[FF_RECV_WARN];
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= RST_BYTE[5:0];
    end else begin
      status <= next_status;
    end
  end

  // interrupt enable and flag registers
  logic [7:0] irqEnable;
  logic [7:0] irqFlag;
  logic [1:0] overflow;
  logic [1:0] ovrSet;
  logic [1:0] fullSet;
  logic errSet;
  logic [7:0] hwSet;
  logic [7:0] holdCond;
  logic [7:0] next_irqFlag;

  // full flag still set means the buffer has not been emptied
  assign ovrSet = rxEvt & irqFlag[IRQ_BUF0 +: 2];
  assign fullSet = rxEvt & ~irqFlag[IRQ_BUF0 +: 2];
  assign errSet = (|ovrSet) || (status != next_status);

  always_comb begin
    hwSet = irqEvent;
    hwSet[IRQ_BUF0 +: 2] = hwSet[IRQ_BUF0 +: 2] | fullSet;
    hwSet[IRQ_ERR] = hwSet[IRQ_ERR] | errSet;
    holdCond = irqCond;
    holdCond[IRQ_ERR] = holdCond[IRQ_ERR] | (|overflow);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqEnable <= RST_BYTE;
    end else if (isWrite(cmd, ADDR_IRQ_EN)) begin
      irqEnable <= applyCmd(irqEnable, cmd);
    end
  end

  always_comb begin
    next_irqFlag = irqFlag;
    if (isWrite(cmd, ADDR_IRQ_FLAG)) begin
      // host may set any flag; a clear is held off by a live cause
      next_irqFlag = applyCmd(irqFlag, cmd) | (irqFlag & holdCond);
    end
    next_irqFlag = next_irqFlag | hwSet;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqFlag <= RST_BYTE;
    end else begin
      irqFlag <= next_irqFlag;
    end
  end

  // overflow bits: set wins over a host clear in the same cycle
  logic [7:0] faultWritten;
  assign faultWritten = applyCmd({overflow, status}, cmd);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overflow <= RST_BYTE[1:0];
    end else if (isWrite(cmd, ADDR_FAULT)) begin
      overflow <= faultWritten[FF_OVR0 +: 2] | ovrSet;
    end else begin
      overflow <= overflow | ovrSet;
    end
  end

  // registered pin so it never glitches between flag updates
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqN <= 1'b1;
    end else begin
      irqN <= ~|(next_irqFlag & irqEnable);
    end
  end

  // read path, one cycle after the command
  logic [7:0] readByte;
  always_comb begin
    case (cmd.addr)
      ADDR_OUT_COUNT: readByte = snap.sendCount;
      ADDR_IN_COUNT: readByte = snap.recvCount;
      ADDR_IRQ_EN: readByte = irqEnable;
      ADDR_IRQ_FLAG: readByte = irqFlag;
      ADDR_FAULT: readByte = {overflow, status};
      default: readByte = UNMAPPED_BYTE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData <= RST_BYTE;
    end else begin
      rdValid <= cmd.valid && (cmd.op == CEFI_OP_READ);
      rdData <= (cmd.valid && cmd.op == CEFI_OP_READ) ? readByte : RST_BYTE;
    end
  end

endmodule

// file: common/cefi_pkg.sv
// constants and carrier types for the CAN fault flag and interrupt block
// assumes an 8-bit register space reached through a decoded command port
package cefi_pkg;
  // register offsets
  localparam logic [7:0] ADDR_OUT_COUNT = 8'h1c;
  localparam logic [7:0] ADDR_IN_COUNT = 8'h1d;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h2b;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h2c;
  localparam logic [7:0] ADDR_FAULT = 8'h2d;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
  // fault_flags field positions
  localparam int FF_OVR1 = 7;
  localparam int FF_OVR0 = 6;
  localparam int FF_BUS_OFF = 5;
  localparam int FF_SEND_PASSIVE = 4;
  localparam int FF_RECV_PASSIVE = 3;
  localparam int FF_SEND_WARN = 2;
  localparam int FF_RECV_WARN = 1;
  localparam int FF_ANY_WARN = 0;
  localparam logic [7:0] FF_HOST_MASK = 8'hc0;
  // irq_flag_bits positions driven by this block
  localparam int IRQ_BUF0 = 0;
  localparam int IRQ_ERR = 5;
  localparam int IRQ_SOURCES = 8;
  // limits
  localparam logic [7:0] WARN_LIMIT = 8'h60;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h80;
  localparam int RUN_LEN = 11;
  localparam int RUN_COUNT = 128;

  typedef enum logic [1:0] {
    CEFI_OP_READ,
    CEFI_OP_WRITE,
    CEFI_OP_MODIFY,
    CEFI_OP_NONE
  } cefi_op_t;

  typedef struct packed {
    logic valid;
    cefi_op_t op;
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] data;
  } cefi_cmd_t;

  typedef struct packed {
    logic [7:0] sendCount;
    logic [7:0] recvCount;
    logic busOff;
  } cefi_snap_t;
endpackage

// file: sim/cefi_fault_irq_monitor.sv
// port assertions for the fault flag and interrupt block
// assumes binding onto cefi_fault_irq; all checks on sys_clk
module cefi_fault_irq_monitor
  import cefi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire cefi_cmd_t cmd,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire logic [IRQ_SOURCES-1:0] irqCond,
  input wire logic irqN
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire rdReq = cmd.valid && cmd.op == CEFI_OP_READ;
  wire hostWr = cmd.valid && cmd.op != CEFI_OP_READ
    && (cmd.addr == ADDR_IRQ_EN || cmd.addr == ADDR_IRQ_FLAG);
  sequence s_en_all;
    hostWr && cmd.addr == ADDR_IRQ_EN && cmd.data == 8'hff;
  endsequence
  sequence s_set0;
    hostWr && cmd.addr == ADDR_IRQ_FLAG && cmd.data == 8'h01;
  endsequence
  property p_rd_ans; rdReq |=> rdValid; endproperty
  property p_rd_only; rdValid |-> $past(rdReq); endproperty
  property p_rd_zero; !rdValid |-> rdData == 8'h00; endproperty
  property p_unmap; rdReq && cmd.addr == 8'h00 |=> rdData == 8'h00;
  endproperty
  property p_rst; $fell(rst) |-> irqN && !rdValid; endproperty
  // enable writes land one edge later than flag writes
  property p_rise; $rose(irqN) |-> $past(hostWr) || $past(hostWr, 2);
  endproperty
  property p_set_low; s_en_all ##2 s_set0 |=> !irqN; endproperty
  property p_hold; irqCond == 8'hff && !irqN && hostWr
    && cmd.addr == ADDR_IRQ_FLAG && !$past(cmd.valid) |=> !irqN;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  a_rd_only: assert property (p_rd_only) else $error("stray read");
  a_rd_zero: assert property (p_rd_zero) else $error("data idle");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  a_rst: assert property (p_rst) else $error("reset outputs");
  a_rise: assert property (p_rise) else $error("pin rose alone");
  a_set_low: assert property (p_set_low) else $error("host set");
  a_hold: assert property (p_hold) else $error("clear not held");
endmodule
bind cefi_fault_irq cefi_fault_irq_monitor u_mon (.sys_clk(sys_clk),
  .rst(rst), .cmd(cmd), .rdValid(rdValid), .rdData(rdData),
  .irqCond(irqCond), .irqN(irqN));

// file: sim/cefi_link_model.sv
// protocol engine stand-in: free-running bit clock, counts and events
// assumes the bench calls its tasks; values hold between calls
module cefi_link_model (
  output logic linkClk,
  output logic [7:0] linkSendCount,
  output logic [7:0] linkRecvCount,
  output logic linkSendOverflow,
  output logic linkRecessive,
  output logic [1:0] linkRxAccept
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {linkSendCount, linkRecvCount} = 16'h0000;
    {linkSendOverflow, linkRecessive, linkRxAccept} = 4'h0;
    linkClk = 1'b0;
    #3;
    forever #24 linkClk = ~linkClk;
  end
  task automatic counts(input logic [7:0] s, input logic [7:0] r);
    @(negedge linkClk);
    linkSendCount = s;
    linkRecvCount = r;
  endtask
  // spaced out so two events on one buffer never merge
  task automatic accept(input int b);
    @(negedge linkClk);
    linkRxAccept = 2'(1 << b);
    @(negedge linkClk);
    linkRxAccept = 2'h0;
    repeat (6) @(negedge linkClk);
  endtask
  task automatic overflow;
    @(negedge linkClk);
    linkSendOverflow = 1'b1;
    @(negedge linkClk);
    linkSendOverflow = 1'b0;
  endtask
  task automatic recessive(input int n);
    @(negedge linkClk);
    linkRecessive = 1'b1;
    repeat (n) @(negedge linkClk);
    linkRecessive = 1'b0;
  endtask
endmodule

// file: sim/can_error_flags_and_irq_tb_top.sv
// self-checking bench for the fault flag and interrupt block
// assumes the link model supplies linkClk and the link-side events
module can_error_flags_and_irq_tb_top;
  import cefi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, rdValid, irqN, linkClk, linkOvf, linkRec;
  logic [7:0] rdData, irqEvent, irqCond, linkSend, linkRecv;
  logic [1:0] linkAcc;
  cefi_cmd_t cmd;
  int err_count = 0, checked = 0, cycles = 0;
  logic [23:0] tbl [5] = '{24'h5f5f00, 24'h600005, 24'h006003,
    24'h7f800f, 24'h800015};
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  cefi_fault_irq u_dut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd),
    .rdValid(rdValid), .rdData(rdData), .irqEvent(irqEvent),
    .irqCond(irqCond), .irqN(irqN), .linkClk(linkClk),
    .linkSendCount(linkSend), .linkRecvCount(linkRecv),
    .linkSendOverflow(linkOvf), .linkRecessive(linkRec),
    .linkRxAccept(linkAcc));
  cefi_link_model u_link (.linkClk(linkClk), .linkSendCount(linkSend),
    .linkRecvCount(linkRecv), .linkSendOverflow(linkOvf),
    .linkRecessive(linkRec), .linkRxAccept(linkAcc));
  task automatic chk(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic send(input cefi_op_t op, input logic [7:0] a, m, d);
    @(negedge sys_clk);
    cmd = '{1'b1, op, a, m, d};
    @(negedge sys_clk);
    cmd.valid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    send(CEFI_OP_READ, a, 8'h00, 8'h00);
    // answer stands only between the two edges after the command
    chk("rdValid", 8'h01, {7'h0, rdValid});
    chk("rdData", e, rdData);
  endtask
  task automatic pin(input logic e);
    @(negedge sys_clk);
    chk("irqN", {7'h0, e}, {7'h0, irqN});
  endtask
  task automatic summarize;
    $display("counts: %0d checked, %0d bad", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {rst, cmd, irqEvent, irqCond} = {1'b1, 27'h0, 16'h0000};
    // link side needs three of its own edges in reset
    repeat (25) @(negedge sys_clk);
    rst = 1'b0;
    rd(ADDR_IN_COUNT, RST_BYTE);
    rd(ADDR_FAULT, RST_BYTE);
    rd(8'h00, RST_BYTE);
    foreach (tbl[i]) begin
      u_link.counts(tbl[i][23:16], tbl[i][15:8]);
      // snapshot round trip can take two handshake loops
      repeat (80) @(negedge sys_clk);
      rd(ADDR_IN_COUNT, tbl[i][15:8]);
      rd(ADDR_OUT_COUNT, tbl[i][23:16]);
      rd(ADDR_FAULT, tbl[i][7:0]);
    end
    send(CEFI_OP_WRITE, ADDR_FAULT, 8'h00, 8'hff);
    send(CEFI_OP_WRITE, ADDR_IN_COUNT, 8'h00, 8'hff);
    rd(ADDR_FAULT, 8'hd5);
    rd(ADDR_IN_COUNT, 8'h00);
    send(CEFI_OP_MODIFY, ADDR_FAULT, 8'hc0, 8'h00);
    u_link.counts(8'h00, 8'h00);
    repeat (80) @(negedge sys_clk);
    send(CEFI_OP_MODIFY, ADDR_IRQ_FLAG, 8'hff, 8'h00);
    rd(ADDR_IRQ_FLAG, 8'h00);
    $display("test status done");
    send(CEFI_OP_WRITE, ADDR_IRQ_EN, 8'h00, 8'hff);
    for (int i = 0; i < IRQ_SOURCES; i++) begin
      @(negedge sys_clk);
      irqEvent = 8'(1 << i);
      @(negedge sys_clk);
      irqEvent = 8'h00;
      pin(1'b0);
      irqCond = 8'hff;
      send(CEFI_OP_MODIFY, ADDR_IRQ_FLAG, 8'(1 << i), 8'h00);
      rd(ADDR_IRQ_FLAG, 8'(1 << i));
      irqCond = 8'h00;
      send(CEFI_OP_MODIFY, ADDR_IRQ_FLAG, 8'(1 << i), 8'h00);
      pin(1'b1);
    end
    send(CEFI_OP_WRITE, ADDR_IRQ_EN, 8'h00, 8'h00);
    send(CEFI_OP_WRITE, ADDR_IRQ_FLAG, 8'h00, 8'h01);
    pin(1'b1);
    send(CEFI_OP_WRITE, ADDR_IRQ_EN, 8'h00, 8'hff);
    send(CEFI_OP_WRITE, ADDR_IRQ_FLAG, 8'h00, 8'h01);
    pin(1'b0);
    send(CEFI_OP_MODIFY, ADDR_IRQ_FLAG, 8'hff, 8'h00);
    pin(1'b1);
    $display("test interrupts done");
    for (int b = 0; b < 2; b++) begin
      u_link.accept(b);
      u_link.accept(b);
      rd(ADDR_FAULT, b ? 8'hc0 : 8'h40);
    end
    $display("test overflow done");
    u_link.overflow();
    u_link.recessive(1397);
    repeat (10) @(negedge sys_clk);
    rd(ADDR_FAULT, 8'he0);
    u_link.recessive(22);
    repeat (80) @(negedge sys_clk);
    rd(ADDR_FAULT, 8'hc0);
    $display("test bus off done");
    summarize();
  end
endmodule
